// ### include/load_shaper_regs.svh
// What this block does
// RL1 - ramp begins at the start load
// RL2 - load steps by step size per duration
// RL3 - ramp ends at end load, reported
// RL4 - millisecond step units up to 100G
// RL5 - after ramp: keep, repeat or invert
// RL6 - constant size uses start size always; with bursts on, frames use burst_frame_size instead
// RL7 - stepped size advances per duration seconds
// RL8 - continuous duration repeats step sequence
// RL9 - seconds duration stops after total time
// RL10 - frame duration stops at frame count
// RL11 - random size uniform start to end
// RL12 - incremental size grows one byte
// RL13 - at 400G only constant and random
// RL14 - size excludes preamble and gap
// RL15 - tiny frames on sfp may underfill
// RL16 - twelve byte gap means full load
// RL17 - burst mode sends only bursts
// RL18 - burst off, fixed or ramped
// RL19 - burst count limit stops stream
// RL20 - gap length is mean burst spacing
// RL21 - fixed burst length from duty, period
// RL22 - ramped burst length follows ramp mode
// RL23 - burst frame counts size plus twenty
// RL24 - settings change only at frame boundary
`ifndef LOAD_SHAPER_REGS_SVH
`define LOAD_SHAPER_REGS_SVH
`define CLK_HZ         20000000
`define MS_CYCLES      (`CLK_HZ / 1000)
`define SEC_CYCLES     `CLK_HZ
`define OVERHEAD_BYTES 16'h0014
`define FULL_IFG_BYTES 16'h000C
`define LFSR_SEED      16'hACE1
`endif

// ### include/load_shaper_pkg.sv
`default_nettype none
package load_shaper_pkg;
   typedef enum logic [1:0] {
      RAMP_KEEP   = 2'h0,
      RAMP_REPEAT = 2'h1,
      RAMP_INVERT = 2'h2
   } ramp_mode_e;
   typedef enum logic [1:0] {
      SIZE_CONST = 2'h0,
      SIZE_STEP  = 2'h1,
      SIZE_RAND  = 2'h2,
      SIZE_INCR  = 2'h3
   } size_mode_e;
   typedef enum logic [1:0] {
      DUR_CONT   = 2'h0,
      DUR_SECS   = 2'h1,
      DUR_FRAMES = 2'h2
   } dur_mode_e;
   typedef enum logic [1:0] {
      BURST_OFF   = 2'h0,
      BURST_FIXED = 2'h1,
      BURST_RAMP  = 2'h2
   } burst_mode_e;
   typedef struct packed {
      logic [15:0] size;
      logic [15:0] gap;
      logic        burst_first;
   } frame_desc_s;
endpackage : load_shaper_pkg
`default_nettype wire

// ### rtl/ethernet_traffic_load_shaper.sv
`include "load_shaper_regs.svh"
`default_nettype none
module ethernet_traffic_load_shaper (
   // clock and reset
   input  wire  logic                       ref_clk,
   input  wire  logic                       sys_rst,
   // run control
   input  wire  logic                       run,
   input  wire  logic                       rate_400g,
   input  wire  logic                       rate_le_100g,
   // line load ramp, load as an average gap in bytes
   input  wire  logic                       ramp_enable,
   input  wire  logic [15:0]                load_start,
   input  wire  logic [15:0]                load_end,
   input  wire  logic [15:0]                load_step,
   input  wire  logic [15:0]                step_duration,
   input  wire  logic                       msec_ramp,
   input  wire  load_shaper_pkg::ramp_mode_e ramp_mode,
   // frame size sequencing
   input  wire  load_shaper_pkg::size_mode_e size_mode,
   input  wire  logic [15:0]                size_start,
   input  wire  logic [15:0]                size_end,
   input  wire  logic [15:0]                size_step,
   input  wire  logic [15:0]                size_duration,
   input  wire  load_shaper_pkg::dur_mode_e  dur_mode,
   input  wire  logic [31:0]                dur_value,
   // bursts
   input  wire  load_shaper_pkg::burst_mode_e burst_mode,
   input  wire  logic                       burst_select,
   input  wire  logic                       burst_limit_en,
   input  wire  logic [15:0]                burst_count_limit,
   input  wire  logic [15:0]                burst_length,
   input  wire  logic                       burst_use_duty,
   input  wire  logic [15:0]                burst_period_bytes,
   input  wire  logic [7:0]                 burst_duty_pct,
   input  wire  logic [15:0]                burst_start,
   input  wire  logic [15:0]                burst_end,
   input  wire  logic [15:0]                burst_gap,
   input  wire  logic [15:0]                burst_frame_size,
   // frame descriptor stream
   output logic                             desc_valid,
   output load_shaper_pkg::frame_desc_s      desc_data,
   input  wire  logic                       desc_ready,
   // status
   output logic [15:0]                      load_now,
   output logic [15:0]                      load_setting,
   output logic                             stopped
);

   // ****************
   // helpers
   // ****************

   // one step of a level toward a target, clamped so it never overshoots
   function automatic logic [15:0] step_toward(input logic [15:0] cur,
      input logic [15:0] tgt, input logic [15:0] stp);
      logic [16:0] s;
      s = 17'h00000;
      if (cur < tgt) begin
         s = {1'b0, cur} + {1'b0, stp};
         step_toward = (s >= {1'b0, tgt}) ? tgt : s[15:0];
      end else begin
         step_toward = (cur - tgt <= stp) ? tgt : cur - stp;
      end
   endfunction : step_toward

   // frames that fit one duty window plus one more, each frame costing size plus overhead
   function automatic logic [15:0] duty_frames(input logic [15:0] per,
      input logic [7:0] pct, input logic [15:0] fsz);
      logic [31:0] on_bytes;
      logic [16:0] cost;
      on_bytes = ({16'h0000, per} * {24'h000000, pct}) / 32'h00000064;
      // RL23 burst frame cost
      cost = {1'b0, fsz} + {1'b0, `OVERHEAD_BYTES};
      duty_frames = 16'((on_bytes / {15'h0000, cost}) + 32'h00000001);
   endfunction : duty_frames

   // ****************
   // time bases
   // ****************
   logic [31:0] ms_cnt_ff;
   logic [15:0] ms_in_sec_ff;
   logic        ms_tick;
   logic        sec_tick;
   assign ms_tick  = (ms_cnt_ff == 32'(`MS_CYCLES - 1));
   assign sec_tick = ms_tick && (ms_in_sec_ff == 16'h03E7);

   // free millisecond and second enables while running
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         ms_cnt_ff    <= 32'h0;
         ms_in_sec_ff <= 16'h0000;
      end else if (ms_tick) begin
         ms_cnt_ff    <= 32'h0;
         ms_in_sec_ff <= (ms_in_sec_ff == 16'h03E7) ? 16'h0000
                                                     : ms_in_sec_ff + 16'h0001;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + 32'h1;
      end
   end

   // RL4 ms units only allowed at 100G or less
   logic step_tick;
   assign step_tick = (msec_ramp && rate_le_100g) ? ms_tick : sec_tick;

   // ****************
   // frame boundary: one descriptor is accepted by the buffer
   // ****************
   logic        in_ready;
   logic        in_valid;
   logic        fire;
   logic        stopped_ff;
   assign fire = in_valid && in_ready;

   // ****************
   // line load ramp
   // ****************
   logic [15:0] load_ff;
   logic [15:0] ramp_lo_ff;
   logic [15:0] ramp_hi_ff;
   logic [15:0] load_hold_ff;
   logic        load_due_ff;

   // RL2 dwell counter per level
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         load_hold_ff <= 16'h0000;
         load_due_ff  <= 1'b0;
      end else begin
         if (step_tick) begin
            if (load_hold_ff + 16'h0001 >= step_duration) begin
               load_hold_ff <= 16'h0000;
               load_due_ff  <= 1'b1;
            end else begin
               load_hold_ff <= load_hold_ff + 16'h0001;
            end
         end
         // RL24 step taken at frame boundary
         if (fire && load_due_ff) begin
            load_due_ff <= 1'b0;
         end
      end
   end

   // RL1 RL2 RL3 RL5 ramp stepping and continuation
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         load_ff    <= ramp_enable ? load_start : load_end;
         ramp_lo_ff <= load_start;
         ramp_hi_ff <= load_end;
      end else if (ramp_enable && fire && load_due_ff) begin
         if (load_ff != ramp_hi_ff) begin
            load_ff <= step_toward(load_ff, ramp_hi_ff, load_step);
         end else begin
            case (ramp_mode)
               load_shaper_pkg::RAMP_REPEAT: load_ff <= ramp_lo_ff;
               load_shaper_pkg::RAMP_INVERT: begin
                  ramp_lo_ff <= ramp_hi_ff;
                  ramp_hi_ff <= ramp_lo_ff;
                  load_ff    <= step_toward(load_ff, ramp_lo_ff, load_step);
               end
               default: load_ff <= load_ff;
            endcase
         end
      end
   end

   // ****************
   // frame size sequencing
   // ****************
   logic [15:0] size_ff;
   logic [15:0] size_hold_ff;
   logic [31:0] elapsed_ff;
   logic [31:0] frames_ff;
   logic [15:0] lfsr_ff;
   logic [15:0] span;
   logic [15:0] rand_size;
   load_shaper_pkg::size_mode_e eff_mode;

   // RL13 only constant and random at 400G
   always_comb begin
      eff_mode = size_mode;
      if (rate_400g && (size_mode == load_shaper_pkg::SIZE_STEP ||
                        size_mode == load_shaper_pkg::SIZE_INCR)) begin
         eff_mode = load_shaper_pkg::SIZE_CONST;
      end
   end

   // RL11 uniform pick in start..end
   assign span      = size_end - size_start + 16'h0001;
   assign rand_size = size_start +
                      16'(({16'h0000, lfsr_ff} * {16'h0000, span}) >> 16);

   // pseudo random source, advanced per frame
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         lfsr_ff <= `LFSR_SEED;
      end else if (fire) begin
         lfsr_ff <= {lfsr_ff[14:0],
                     lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      end
   end

   // RL6 RL7 RL8 RL12 size per frame
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         size_ff      <= size_start;
         size_hold_ff <= 16'h0000;
      end else begin
         case (eff_mode)
            load_shaper_pkg::SIZE_STEP: begin
               if (sec_tick) begin
                  if (size_hold_ff + 16'h0001 >= size_duration) begin
                     size_hold_ff <= 16'h0000;
                     // RL8 wrap to start
                     size_ff <= (size_ff >= size_end) ? size_start
                              : step_toward(size_ff, size_end, size_step);
                  end else begin
                     size_hold_ff <= size_hold_ff + 16'h0001;
                  end
               end
            end
            load_shaper_pkg::SIZE_INCR: begin
               if (fire) begin
                  size_ff <= (size_ff >= size_end) ? size_start
                                                   : size_ff + 16'h0001;
               end
            end
            load_shaper_pkg::SIZE_RAND: begin
               if (fire) begin
                  size_ff <= rand_size;
               end
            end
            default: size_ff <= size_start;
         endcase
      end
   end

   // RL9 RL10 elapsed time and frame counts
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         elapsed_ff <= 32'h0;
         frames_ff  <= 32'h0;
      end else begin
         if (sec_tick) begin
            elapsed_ff <= elapsed_ff + 32'h1;
         end
         if (fire) begin
            frames_ff <= frames_ff + 32'h1;
         end
      end
   end

   // ****************
   // bursts
   // ****************
   logic [15:0] burst_len_ff;
   logic [15:0] burst_lo_ff;
   logic [15:0] burst_hi_ff;
   logic [15:0] in_burst_ff;
   logic [15:0] bursts_ff;
   logic [15:0] fixed_len;
   logic        burst_on;
   logic        last_in_burst;
   logic [15:0] rgap;
   assign burst_on  = burst_select && !rate_400g;
   // RL21 length from duty and period
   assign fixed_len = burst_use_duty
                    ? duty_frames(burst_period_bytes, burst_duty_pct,
                                  burst_frame_size)
                    : burst_length;
   assign last_in_burst = (in_burst_ff + 16'h0001 >= burst_len_ff);
   // RL20 gap drawn around its mean, 0..2x
   assign rgap = 16'(({16'h0000, lfsr_ff} * {15'h0000, burst_gap, 1'b0})
                     >> 16);

   // RL18 RL19 RL22 burst length and count
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         burst_len_ff <= (burst_mode == load_shaper_pkg::BURST_RAMP)
                       ? burst_start : fixed_len;
         burst_lo_ff  <= burst_start;
         burst_hi_ff  <= burst_end;
         in_burst_ff  <= 16'h0000;
         bursts_ff    <= 16'h0000;
      end else if (burst_on && fire) begin
         if (last_in_burst) begin
            in_burst_ff <= 16'h0000;
            bursts_ff   <= bursts_ff + 16'h0001;
            // RL24 new length at burst boundary
            if (burst_mode == load_shaper_pkg::BURST_RAMP) begin
               if (burst_len_ff != burst_hi_ff) begin
                  burst_len_ff <= step_toward(burst_len_ff, burst_hi_ff,
                                              16'h0001);
               end else begin
                  case (ramp_mode)
                     load_shaper_pkg::RAMP_REPEAT: burst_len_ff <= burst_lo_ff;
                     load_shaper_pkg::RAMP_INVERT: begin
                        burst_lo_ff <= burst_hi_ff;
                        burst_hi_ff <= burst_lo_ff;
                     end
                     default: burst_len_ff <= burst_len_ff;
                  endcase
               end
            end else begin
               burst_len_ff <= fixed_len;
            end
         end else begin
            in_burst_ff <= in_burst_ff + 16'h0001;
         end
      end
   end

   // ****************
   // stop conditions
   // ****************
   logic stop_now;
   always_comb begin
      stop_now = 1'b0;
      if (burst_on) begin
         // RL18 off stops the stream
         if (burst_mode == load_shaper_pkg::BURST_OFF) begin
            stop_now = 1'b1;
         end
         // RL19 count limit reached
         if (burst_limit_en && bursts_ff >= burst_count_limit) begin
            stop_now = 1'b1;
         end
      end else if (eff_mode == load_shaper_pkg::SIZE_STEP) begin
         if (dur_mode == load_shaper_pkg::DUR_SECS &&
             elapsed_ff >= dur_value) begin
            stop_now = 1'b1;
         end
         if (dur_mode == load_shaper_pkg::DUR_FRAMES &&
             frames_ff >= dur_value) begin
            stop_now = 1'b1;
         end
      end
   end

   // latched so a stop is never undone mid-run
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !run) begin
         stopped_ff <= 1'b0;
      end else if (stop_now) begin
         stopped_ff <= 1'b1;
      end
   end

   // ****************
   // descriptor build and two-entry buffer
   // ****************
   load_shaper_pkg::frame_desc_s in_desc;
   assign in_valid = run && !stopped_ff && !stop_now;
   always_comb begin
      // RL14 size excludes preamble and gap
      in_desc.size        = size_ff;
      // RL16 RL17 gap is load gap; in bursts 12 bytes, or burst gap after the last frame
      in_desc.gap         = load_ff;
      in_desc.burst_first = burst_on && (in_burst_ff == 16'h0000);
      if (burst_on) begin
         in_desc.size = burst_frame_size;
         in_desc.gap  = last_in_burst ? rgap : `FULL_IFG_BYTES;
      end
   end

   load_shaper_pkg::frame_desc_s buf_ff [2];
   logic [1:0] cnt_ff;
   logic       rd_ff;
   logic       wr_ff;
   logic       pop;
   assign in_ready = (cnt_ff != 2'h2);
   assign pop      = (cnt_ff != 2'h0) && (!desc_valid || desc_ready);

   // storage: stalls on the output fill it, then refuse the input
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_ff <= 2'h0;
         rd_ff  <= 1'b0;
         wr_ff  <= 1'b0;
      end else begin
         if (fire) begin
            buf_ff[wr_ff] <= in_desc;
            wr_ff         <= ~wr_ff;
         end
         if (pop) begin
            rd_ff <= ~rd_ff;
         end
         cnt_ff <= cnt_ff + {1'b0, fire} - {1'b0, pop};
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         desc_valid   <= 1'b0;
         desc_data    <= '0;
         load_now     <= 16'h0000;
         load_setting <= 16'h0000;
         stopped      <= 1'b0;
      end else begin
         // output word refilled only when empty or taken
         if (!desc_valid || desc_ready) begin
            desc_valid <= (cnt_ff != 2'h0);
            desc_data  <= buf_ff[rd_ff];
         end
         load_now     <= load_ff;
         // RL3 end load reported
         load_setting <= load_end;
         stopped      <= stopped_ff;
      end
   end

endmodule : ethernet_traffic_load_shaper
`default_nettype wire

// ### testbench/load_shaper_properties.sv
`default_nettype none
module load_shaper_properties (
   // clock and reset
   input wire logic                          ref_clk,
   input wire logic                          sys_rst,
   // configuration seen by the rules
   input wire logic                          ramp_enable,
   input wire logic [15:0]                   load_start,
   input wire logic [15:0]                   load_end,
   input wire load_shaper_pkg::size_mode_e   size_mode,
   input wire logic [15:0]                   size_start,
   input wire logic [15:0]                   size_end,
   input wire logic                          burst_select,
   input wire load_shaper_pkg::burst_mode_e  burst_mode,
   // descriptor stream and status
   input wire logic                          desc_valid,
   input wire load_shaper_pkg::frame_desc_s  desc_data,
   input wire logic                          desc_ready,
   input wire logic [15:0]                   load_now,
   input wire logic [15:0]                   load_setting,
   input wire logic                          stopped
);
   logic        xfer;
   logic [15:0] last_size_ff;
   logic        have_last_ff;
   assign xfer = desc_valid && desc_ready;
   // remember the last accepted size, the next one is judged against it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         have_last_ff <= 1'b0;
         last_size_ff <= 16'h0000;
      end else if (xfer) begin
         have_last_ff <= 1'b1;
         last_size_ff <= desc_data.size;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ready held for four cycles is enough to empty the two-entry buffer
   sequence s_off_drained;
      (burst_select && burst_mode == load_shaper_pkg::BURST_OFF &&
       desc_ready) [*4];
   endsequence
   sequence s_stop_drained;
      (stopped && desc_ready) [*4];
   endsequence
   chk_hold_stalled: assert property (
      desc_valid && !desc_ready |=> desc_valid && $stable(desc_data))
      else $error("descriptor changed while stalled");
   chk_const_size: assert property (
      desc_valid && size_mode == load_shaper_pkg::SIZE_CONST &&
      !burst_select |-> desc_data.size == size_start)
      else $error("constant size differs from start size");
   chk_rand_range: assert property (
      desc_valid && size_mode == load_shaper_pkg::SIZE_RAND |->
      desc_data.size >= size_start && desc_data.size <= size_end)
      else $error("random size out of range");
   chk_incr_step: assert property (
      xfer && have_last_ff && size_mode == load_shaper_pkg::SIZE_INCR |->
      desc_data.size == last_size_ff + 16'h0001 ||
      desc_data.size == size_start)
      else $error("incremental size did not grow by one");
   chk_load_report: assert property (
      ramp_enable && $stable(load_end) |=> load_setting == load_end)
      else $error("load setting is not the end load");
   chk_load_bounds: assert property (
      ramp_enable && load_start <= load_end |-> ##1
      load_now >= load_start && load_now <= load_end)
      else $error("load left the ramp range");
   chk_off_silent: assert property (
      s_off_drained |-> !desc_valid)
      else $error("descriptor offered with bursts off");
   chk_stop_silent: assert property (
      s_stop_drained |-> !desc_valid)
      else $error("descriptor offered after stop");
endmodule : load_shaper_properties
bind ethernet_traffic_load_shaper load_shaper_properties
   u_load_shaper_properties (.ref_clk, .sys_rst, .ramp_enable, .load_start,
   .load_end, .size_mode, .size_start, .size_end, .burst_select,
   .burst_mode, .desc_valid, .desc_data, .desc_ready, .load_now,
   .load_setting, .stopped);
`default_nettype wire

// ### testbench/frame_sink_model.sv
`default_nettype none
module frame_sink_model (
   // clock
   input  wire logic ref_clk,
   // stall control from the bench
   input  wire logic stall_en,
   // acceptance towards the descriptor stream
   output logic      desc_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_ff = 2'h0;
   // a congested link takes one word in four, so the buffer fills
   always @(posedge ref_clk) begin
      phase_ff <= phase_ff + 2'h1;
      desc_ready <= #1 !stall_en || (phase_ff == 2'h3);
   end
endmodule : frame_sink_model
`default_nettype wire

// ### testbench/tb_top.sv
`include "load_shaper_regs.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, sys_rst, run, rate_400g, rate_le_100g, ramp_enable;
   logic msec_ramp, burst_select, burst_limit_en, burst_use_duty, stall_en;
   logic desc_valid, desc_ready, stopped;
   logic [15:0] load_start, load_end, load_step, step_duration, size_start;
   logic [15:0] size_end, size_step, size_duration, burst_count_limit;
   logic [15:0] burst_length, burst_period_bytes, burst_start, burst_end;
   logic [15:0] burst_gap, burst_frame_size, load_now, load_setting;
   logic [7:0]  burst_duty_pct;
   logic [31:0] dur_value;
   load_shaper_pkg::ramp_mode_e  ramp_mode;
   load_shaper_pkg::size_mode_e  size_mode;
   load_shaper_pkg::dur_mode_e   dur_mode;
   load_shaper_pkg::burst_mode_e burst_mode;
   load_shaper_pkg::frame_desc_s desc_data;
   int fail_count, comparisons;

   ethernet_traffic_load_shaper u_ethernet_traffic_load_shaper (.ref_clk,
      .sys_rst, .run, .rate_400g, .rate_le_100g, .ramp_enable, .load_start,
      .load_end, .load_step, .step_duration, .msec_ramp, .ramp_mode,
      .size_mode, .size_start, .size_end, .size_step, .size_duration,
      .dur_mode, .dur_value, .burst_mode, .burst_select, .burst_limit_en,
      .burst_count_limit, .burst_length, .burst_use_duty,
      .burst_period_bytes, .burst_duty_pct, .burst_start, .burst_end,
      .burst_gap, .burst_frame_size, .desc_valid, .desc_data, .desc_ready,
      .load_now, .load_setting, .stopped);
   frame_sink_model u_frame_sink_model (.ref_clk, .stall_en, .desc_ready);

   always #25 ref_clk = !ref_clk;

   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : check_eq

   task automatic test_done();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   // config is changed only while reset is held, then the run starts
   task automatic start_reset();
      @(posedge ref_clk);
      #1 sys_rst = 1'b1;
      run = 1'b0;
      @(posedge ref_clk);
   endtask : start_reset

   task automatic end_reset();
      @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      run = 1'b1;
   endtask : end_reset

   // a handshake seen at an edge is one accepted frame
   task automatic get_frame(output load_shaper_pkg::frame_desc_s d);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!(desc_valid === 1'b1 && desc_ready === 1'b1) && n < 2000);
      d = desc_data;
      check_eq({31'h0, n < 2000}, 32'h1, "frame wait");
   endtask : get_frame

   task automatic count_idle(output int extra);
      extra = 0;
      repeat (40) begin
         @(posedge ref_clk);
         if (desc_valid === 1'b1 && desc_ready === 1'b1) extra++;
      end
   endtask : count_idle

   task automatic test_const_size();
      load_shaper_pkg::frame_desc_s d;
      start_reset();
      size_mode = load_shaper_pkg::SIZE_CONST;
      end_reset();
      for (int i = 0; i < 6; i++) begin
         get_frame(d);
         check_eq({16'h0, d.size}, {16'h0, size_start}, "const");
      end
      check_eq({16'h0, load_setting}, {16'h0, load_end}, "report");
   endtask : test_const_size

   task automatic test_incr_size();
      load_shaper_pkg::frame_desc_s d;
      logic [15:0] exp;
      start_reset();
      size_mode = load_shaper_pkg::SIZE_INCR;
      size_end = size_start + 16'h0003;
      end_reset();
      for (int i = 0; i < 9; i++) begin
         get_frame(d);
         exp = size_start + 16'(i % 4);
         check_eq({16'h0, d.size}, {16'h0, exp}, "incr");
      end
   endtask : test_incr_size

   // random range under a stalling sink
   task automatic test_rand_stall();
      load_shaper_pkg::frame_desc_s d;
      start_reset();
      size_mode = load_shaper_pkg::SIZE_RAND;
      size_end = 16'h0050;
      stall_en = 1'b1;
      end_reset();
      for (int i = 0; i < 10; i++) begin
         get_frame(d);
         check_eq({31'h0, d.size >= size_start && d.size <= size_end},
                  32'h1, "rand");
      end
      stall_en = 1'b0;
   endtask : test_rand_stall

   // stepped run ends at the frame count
   task automatic test_frame_stop();
      load_shaper_pkg::frame_desc_s d;
      int extra;
      start_reset();
      size_mode = load_shaper_pkg::SIZE_STEP;
      dur_mode = load_shaper_pkg::DUR_FRAMES;
      dur_value = 32'h0000_0005;
      end_reset();
      repeat (5) begin
         get_frame(d);
         check_eq({16'h0, d.size}, {16'h0, size_start}, "step");
      end
      count_idle(extra);
      check_eq(extra, 32'h0, "past count");
      check_eq({31'h0, stopped}, 32'h1, "stop flag");
   endtask : test_frame_stop

   // fixed bursts with a limit, then bursts off
   task automatic test_bursts();
      load_shaper_pkg::frame_desc_s d;
      int extra;
      start_reset();
      dur_mode = load_shaper_pkg::DUR_CONT;
      burst_select = 1'b1;
      burst_mode = load_shaper_pkg::BURST_FIXED;
      burst_limit_en = 1'b1;
      end_reset();
      for (int i = 0; i < 6; i++) begin
         get_frame(d);
         check_eq({31'h0, d.burst_first}, {31'h0, i % 3 == 0}, "first");
      end
      count_idle(extra);
      check_eq(extra, 32'h0, "past bursts");
      start_reset();
      burst_mode = load_shaper_pkg::BURST_OFF;
      end_reset();
      count_idle(extra);
      check_eq(extra, 32'h0, "off");
      start_reset();
      burst_select = 1'b0;
   endtask : test_bursts

   // ramp start load in every mode, invert mode run back to the start load
   task automatic test_ramp();
      for (int m = 0; m < 3; m++) begin
         start_reset();
         ramp_mode = load_shaper_pkg::ramp_mode_e'(m);
         end_reset();
         repeat (4) @(posedge ref_clk);
         check_eq({16'h0, load_now}, {16'h0, load_start}, "ramp start");
      end
      repeat (4 * `MS_CYCLES + 200) @(posedge ref_clk);
      check_eq({16'h0, load_now}, {16'h0, load_start}, "inverted");
   endtask : test_ramp

   initial begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      run = 1'b0;
      {rate_400g, msec_ramp, burst_use_duty, stall_en} = 4'h4;
      {rate_le_100g, ramp_enable, burst_select, burst_limit_en} = 4'hC;
      {load_start, load_end, load_step} = {16'h000C, 16'h0014, 16'h0004};
      step_duration = 16'h0001;
      {size_start, size_end, size_step} = {16'h0040, 16'h0043, 16'h0004};
      size_duration = 16'h0001;
      {burst_count_limit, burst_length} = {16'h0002, 16'h0003};
      {burst_start, burst_end, burst_gap} = {16'h0002, 16'h0004, 16'h0040};
      {burst_period_bytes, burst_frame_size} = {16'h0100, 16'h0040};
      burst_duty_pct = 8'h32;
      dur_value = 32'h0;
      ramp_mode = load_shaper_pkg::RAMP_KEEP;
      size_mode = load_shaper_pkg::SIZE_CONST;
      dur_mode = load_shaper_pkg::DUR_CONT;
      burst_mode = load_shaper_pkg::BURST_FIXED;
      fail_count = 0;
      comparisons = 0;
      repeat (2) @(posedge ref_clk);
      test_const_size();
      test_incr_size();
      test_rand_stall();
      test_frame_stop();
      test_bursts();
      test_ramp();
      test_done();
   end

   // watchdog reckoned from the longest ramp wait plus margin
   initial begin
      #(95000 * 50);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
